// [design/bcas_pkg.sv]
// shared constants and types of the auto sequencer and its controller
// assumes one 125 MHz clock and a synchronous active-low reset
`default_nettype none
package bcas_pkg;
    localparam int BW = 128;
    localparam int WORD_W = 32;
    // auto command codes
    localparam logic [4:0] CMD_ECB = 5'h00;
    localparam logic [4:0] CMD_CTR = 5'h01;
    localparam logic [4:0] CMD_CBC = 5'h02;
    localparam logic [4:0] CMD_MAC = 5'h03;
    localparam logic [4:0] CMD_KW128 = 5'h10;
    localparam logic [4:0] CMD_KW256 = 5'h11;
    localparam int CMD_KEY_BIT = 4;
    // counter increment widths
    localparam logic [1:0] INCR_32 = 2'h0;
    localparam logic [1:0] INCR_64 = 2'h1;
    localparam logic [1:0] INCR_96 = 2'h2;
    localparam logic [1:0] INCR_128 = 2'h3;
    // bank select on the write port
    localparam logic [1:0] BANK_IN0 = 2'h0;
    localparam logic [1:0] BANK_IN1 = 2'h1;
    localparam logic [1:0] BANK_IN2 = 2'h2;
    localparam logic [1:0] BANK_RES = 2'h3;
    // writes a key command waits for
    localparam logic [1:0] NEED_W128 = 2'h1;
    localparam logic [1:0] NEED_W256 = 2'h2;
    localparam logic [1:0] NEED_U128 = 2'h2;
    localparam logic [1:0] NEED_U256 = 2'h3;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PUSH = 8'h0C;
    localparam logic [7:0] OFS_WDAT = 8'h10;
    localparam logic [7:0] OFS_RDAT = 8'h20;
    localparam logic [7:0] OFS_WRAP = 8'h30;
    // control bits
    localparam int CB_AUTO_EN = 0;
    localparam int CB_STOP = 1;
    localparam int CB_START = 2;
    localparam int CB_DECRYPT = 3;
    localparam int CB_KEEP_KEY = 4;
    localparam int CB_NO_UPD = 5;
    localparam int CB_HS_EN = 6;
    localparam int CMD_INCR_LSB = 8;
    // status bits
    localparam int SB_BUSY = 0;
    localparam int SB_REQ_IN = 1;
    localparam int SB_REQ_OUT = 2;
    localparam int SB_UERR = 3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN = 4'b0010,
        ST_DRAIN = 4'b0100,
        ST_KEY = 4'b1000
    } bcas_st_t;
endpackage
`default_nettype wire

// [design/bcas_if.sv]
// link between the sequencer (dev) and its bus-side controller (host)
// one clock domain; all signals are levels sampled on the engine clock
`default_nettype none
interface bcas_if;
    logic auto_en;
    logic auto_stop;
    logic start;
    logic decrypt;
    logic keep_key;
    logic no_update;
    logic hs_en;
    logic [4:0] cmd;
    logic [1:0] incr;
    logic wr_valid;
    logic [1:0] wr_bank;
    logic [bcas_pkg::BW-1:0] wr_data;
    logic wr_ready;
    logic rd_valid;
    logic rd_wrap;
    logic rd_ready;
    logic [bcas_pkg::BW-1:0] rd_data;
    logic [bcas_pkg::BW-1:0] wrap_data;
    logic busy;
    logic req_in;
    logic req_out;
    logic unwrap_err;
    modport dev (
        input auto_en, auto_stop, start, decrypt, keep_key, no_update, hs_en, cmd, incr,
        input wr_valid, wr_bank, wr_data, rd_valid, rd_wrap,
        output wr_ready, rd_ready, rd_data, wrap_data, busy, req_in, req_out, unwrap_err
    );
    modport host (
        output auto_en, auto_stop, start, decrypt, keep_key, no_update, hs_en, cmd, incr,
        output wr_valid, wr_bank, wr_data, rd_valid, rd_wrap,
        input wr_ready, rd_ready, rd_data, wrap_data, busy, req_in, req_out, unwrap_err
    );
endinterface
`default_nettype wire

// [design/bcas_dev.sv]
// auto sequencer: chains cipher kernel operations fed through the banks
// assumes the kernel samples its inputs on the start pulse
//
// Function
// R1 - host ends CBC-MAC: clear, stop, read once
// R2 - CBC-MAC overwrites input banks zero and one
// R3 - CTR start: enable, command 0x01, width, start
// R4 - first CTR op: no-update, decrypt zero
// R5 - CTR: counter in bank zero, data bank one
// R6 - host ends CTR: clear enable, set stop
// R7 - CTR launches on every bank-one load
// R8 - increment width picks counter words
// R9 - keep-key skips key load after first op
// R10 - dma requests on input and output channels
// R11 - requests held until access; done ignored
// R12 - two blocks loaded before first read
// R13 - busy through drain; early read stalls
// R14 - command changed only while not busy
// R15 - wrap: command 0x10/0x11, decrypt zero, start
// R16 - wrap: key in banks, wait, read result
// R17 - key commands 128/256 only, no handshake
// R18 - wrap overwrites result, never loads key
// R19 - unwrap: same codes, decrypt one, banks
// R20 - bad integrity sets error, key still loaded
// R21 - unwrap flushes result, fixed key slot
// R22 - shared KEK slot needs keep-key set
`default_nettype none
module bcas_dev #(
    parameter int KSW = 2,
    parameter logic [1:0] KEY_SLOT = 2'h0
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    bcas_if.dev ifc,
    output logic kern_start_o,
    output logic kern_skip_key_o,
    output logic kern_key_op_o,
    output logic kern_decrypt_o,
    output logic kern_key256_o,
    output logic [bcas_pkg::BW-1:0] kern_din_o,
    output logic [3*bcas_pkg::BW-1:0] kern_key_blk_o,
    input wire logic kern_done_i,
    input wire logic [bcas_pkg::BW-1:0] kern_res_i,
    input wire logic kern_icv_bad_i,
    output logic key_load_o,
    output logic [KSW-1:0] key_slot_o
);
    import bcas_pkg::*;

    typedef struct packed {
        bcas_st_t st;
        logic [BW-1:0] in0;
        logic [BW-1:0] in1;
        logic [BW-1:0] in2;
        logic [BW-1:0] res;
        logic [BW-1:0] wrp;
        logic [BW-1:0] kin;
        logic [BW-1:0] hold;
        logic pend;
        logic kbusy;
        logic kick;
        logic kskip;
        logic kkey;
        logic rvalid;
        logic macfin;
        logic first;
        logic uerr;
        logic key_load;
        logic [1:0] cnt;
    } bcas_dev_q_t;

    localparam bcas_dev_q_t DEV_RST = '{st: ST_IDLE, default: '0};

    bcas_dev_q_t q;
    bcas_dev_q_t n;
    logic is_ctr;
    logic is_mac;
    logic is_key;
    logic auto_on;
    logic out_blocked;
    logic wr_go;
    logic rd_go;
    logic launch;
    logic [1:0] need;

    function automatic logic [BW-1:0] ctr_incr(input logic [BW-1:0] v, input logic [1:0] w);
        logic [BW-1:0] mask;
        mask = {BW{1'b1}} >> (WORD_W * (3 - int'(w)));
        return ((v + BW'(1)) & mask) | (v & ~mask);
    endfunction

    function automatic logic [1:0] key_need(input logic k256, input logic dec);
        return dec ? (k256 ? NEED_U256 : NEED_U128) : (k256 ? NEED_W256 : NEED_W128);
    endfunction

    assign is_ctr = (ifc.cmd == CMD_CTR);
    assign is_mac = (ifc.cmd == CMD_MAC);
    assign is_key = ifc.cmd[CMD_KEY_BIT];
    assign auto_on = (q.st == ST_RUN) || (q.st == ST_DRAIN);
    assign need = key_need(ifc.cmd[0], ifc.decrypt);
    // an unread result holds back the next launch, except under the mac command
    assign out_blocked = q.rvalid && !is_mac;

    assign ifc.wr_ready = !q.pend;
    assign ifc.rd_ready = ifc.rd_wrap || !auto_on || q.rvalid; // R13
    assign ifc.rd_data = q.res;
    assign ifc.wrap_data = q.wrp;
    assign ifc.busy = (q.st != ST_IDLE) || q.kbusy; // R13
    assign ifc.unwrap_err = q.uerr;
    // requests fall when the access lands; req_in also falls when the state leaves ST_RUN
    assign ifc.req_in = ifc.hs_en && (q.st == ST_RUN) && !q.pend; // R10 R11 R17
    assign ifc.req_out = ifc.hs_en && auto_on && q.rvalid && !is_mac; // R10 R11 R17

    assign wr_go = ifc.wr_valid && !q.pend;
    assign rd_go = ifc.rd_valid && ifc.rd_ready;
    assign launch = auto_on && q.pend && !q.kbusy && !out_blocked; // R12

    assign kern_start_o = q.kick;
    assign kern_skip_key_o = q.kskip;
    assign kern_key_op_o = q.kkey;
    assign kern_decrypt_o = ifc.decrypt;
    assign kern_key256_o = ifc.cmd[0];
    assign kern_din_o = q.kin;
    assign kern_key_blk_o = {q.in2, q.in1, q.in0};
    assign key_load_o = q.key_load;
    assign key_slot_o = KSW'(KEY_SLOT); // R21

    always_comb begin
        n = q;
        n.kick = 1'b0;
        n.key_load = 1'b0;
        if (wr_go) begin
            unique case (ifc.wr_bank)
                BANK_IN0: n.in0 = ifc.wr_data;
                BANK_IN1: n.in1 = ifc.wr_data;
                BANK_IN2: n.in2 = ifc.wr_data;
                BANK_RES: n.res = ifc.wr_data;
            endcase
            // ctr launches on bank one, the chained modes on bank zero
            if (auto_on && (ifc.wr_bank == (is_ctr ? BANK_IN1 : BANK_IN0))) begin
                n.pend = 1'b1; // R7 R5
            end
            if ((q.st == ST_KEY) && (q.cnt != need)) begin
                n.cnt = q.cnt + 2'h1; // R16 R19
            end
        end
        if (rd_go && !ifc.rd_wrap && auto_on) begin
            n.rvalid = 1'b0;
        end
        if (q.kbusy && kern_done_i) begin
            n.kbusy = 1'b0;
            if (q.kkey) begin
                n.st = ST_IDLE;
                if (ifc.decrypt) begin
                    n.key_load = 1'b1; // R20 R21
                    n.uerr = kern_icv_bad_i; // R20
                    n.res = '0; // R21
                end else begin
                    n.res = kern_res_i; // R18
                    n.wrp = kern_res_i; // R18
                end
            end else begin
                n.res = is_ctr ? (kern_res_i ^ q.hold) : kern_res_i;
                n.rvalid = !is_mac; // R1
            end
        end
        if (launch) begin
            n.pend = 1'b0;
            n.kick = 1'b1;
            n.kbusy = 1'b1;
            n.kkey = 1'b0;
            n.first = 1'b0;
            n.kskip = ifc.keep_key && !q.first; // R9
            if (is_ctr) begin
                // ctr never issues a result update op
                n.kin = q.in0; // R7
                n.hold = q.in1;
                n.in0 = ctr_incr(q.in0, ifc.incr); // R8
            end else if (is_mac || (ifc.cmd == CMD_CBC)) begin
                n.kin = q.in0 ^ q.res;
                n.in1 = q.in0 ^ q.res; // R2
                if (is_mac) begin
                    n.in0 = q.in0 ^ q.res; // R2
                end
            end else begin
                n.kin = q.in0;
            end
        end
        unique case (q.st)
            ST_IDLE: begin
                if (ifc.start && ifc.auto_en) begin
                    n.first = 1'b1;
                    n.rvalid = 1'b0;
                    n.macfin = 1'b0;
                    n.pend = 1'b0;
                    n.cnt = 2'h0;
                    n.uerr = is_key ? 1'b0 : q.uerr;
                    n.st = is_key ? ST_KEY : ST_RUN; // R15 R19 R3
                end
            end
            ST_RUN: begin
                // dma done is never looked at
                if (ifc.auto_stop && !ifc.auto_en) begin
                    n.st = ST_DRAIN; // R11 R6 R1
                end
            end
            ST_DRAIN: begin
                if (!q.pend && !q.kbusy) begin
                    if (is_mac && !q.macfin) begin
                        n.rvalid = 1'b1; // R1
                        n.macfin = 1'b1;
                    end else if (!q.rvalid) begin
                        n.st = ST_IDLE; // R13
                    end
                end
            end
            ST_KEY: begin
                // banks always from zero: input selection has no say
                if ((q.cnt == need) && !q.kbusy && !q.kick) begin
                    n.kick = 1'b1; // R17
                    n.kbusy = 1'b1;
                    n.kkey = 1'b1;
                    n.kskip = ifc.keep_key && ifc.decrypt; // R22
                    n.cnt = 2'h0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            q <= DEV_RST;
        end else begin
            q <= n;
        end
    end
endmodule
`default_nettype wire

// [design/bcas_host.sv]
// bus-side controller: apb slave registers that drive the sequencer link
// assumes an apb master on ref_clk_i; dma request lines go to the dma
`default_nettype none
module bcas_host (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    bcas_if.host ifc,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic dma_req_in_o,
    output logic dma_req_out_o
);
    import bcas_pkg::*;

    typedef struct packed {
        logic [6:0] ctrl;
        logic [4:0] cmd;
        logic [1:0] incr;
        logic [BW-1:0] wdat;
        logic [BW-1:0] rblk;
        logic [1:0] bank;
        logic wr_valid;
        logic rd_valid;
        logic rd_wrap;
        logic done;
        logic err;
        logic [31:0] prdata;
    } bcas_host_q_t;

    bcas_host_q_t q;
    bcas_host_q_t n;
    logic access;
    logic [1:0] widx;
    logic [7:0] wbase;

    function automatic logic [31:0] word_of(input logic [BW-1:0] b, input logic [1:0] i);
        return b[WORD_W*i +: WORD_W];
    endfunction

    assign access = psel_i && penable_i && !q.done;
    assign widx = paddr_i[3:2];
    assign wbase = {paddr_i[7:4], 4'h0};

    assign ifc.auto_en = q.ctrl[CB_AUTO_EN];
    assign ifc.auto_stop = q.ctrl[CB_STOP];
    assign ifc.start = q.ctrl[CB_START];
    assign ifc.decrypt = q.ctrl[CB_DECRYPT];
    assign ifc.keep_key = q.ctrl[CB_KEEP_KEY];
    assign ifc.no_update = q.ctrl[CB_NO_UPD];
    assign ifc.hs_en = q.ctrl[CB_HS_EN];
    assign ifc.cmd = q.cmd;
    assign ifc.incr = q.incr;
    assign ifc.wr_valid = q.wr_valid;
    assign ifc.wr_bank = q.bank;
    assign ifc.wr_data = q.wdat;
    assign ifc.rd_valid = q.rd_valid;
    assign ifc.rd_wrap = q.rd_wrap;
    assign prdata_o = q.prdata;
    assign pready_o = q.done;
    assign pslverr_o = q.done && q.err;
    assign dma_req_in_o = ifc.req_in;
    assign dma_req_out_o = ifc.req_out;

    always_comb begin
        n = q;
        n.done = 1'b0;
        n.err = 1'b0;
        // stop and start are one-cycle strobes
        n.ctrl[CB_STOP] = 1'b0;
        n.ctrl[CB_START] = 1'b0;
        if (q.wr_valid && ifc.wr_ready) begin
            n.wr_valid = 1'b0;
            n.done = 1'b1; // R11
        end
        if (q.rd_valid && ifc.rd_ready) begin
            n.rd_valid = 1'b0;
            n.done = 1'b1; // R13
            n.rblk = q.rd_wrap ? ifc.wrap_data : ifc.rd_data;
            n.prdata = word_of(n.rblk, 2'h0); // R16
        end
        if (access && !q.wr_valid && !q.rd_valid) begin
            n.done = 1'b1;
            n.prdata = '0;
            if (pwrite_i) begin
                if (paddr_i == OFS_CTRL) begin
                    n.ctrl = pwdata_i[6:0]; // R1 R3 R6 R15 R19
                end else if (paddr_i == OFS_CMD) begin
                    // a busy engine keeps its command
                    if (!ifc.busy) begin
                        n.cmd = pwdata_i[4:0]; // R14
                        n.incr = pwdata_i[CMD_INCR_LSB +: 2]; // R3
                    end
                end else if (paddr_i == OFS_PUSH) begin
                    n.bank = pwdata_i[1:0];
                    n.wr_valid = 1'b1; // R5 R12
                    n.done = 1'b0;
                end else if (wbase == OFS_WDAT) begin
                    n.wdat[WORD_W*widx +: WORD_W] = pwdata_i;
                end else begin
                    n.err = 1'b1;
                end
            end else begin
                if (paddr_i == OFS_CTRL) begin
                    n.prdata = {25'h0, q.ctrl};
                end else if (paddr_i == OFS_CMD) begin
                    n.prdata = {22'h0, q.incr, 3'h0, q.cmd};
                end else if (paddr_i == OFS_STATUS) begin
                    n.prdata = {28'h0, ifc.unwrap_err, ifc.req_out, ifc.req_in, ifc.busy};
                end else if (wbase == OFS_WDAT) begin
                    n.prdata = word_of(q.wdat, widx);
                end else if ((paddr_i == OFS_RDAT) || (paddr_i == OFS_WRAP)) begin
                    // word zero pulls a block, higher words read its copy
                    n.rd_valid = 1'b1; // R13
                    n.rd_wrap = (paddr_i == OFS_WRAP);
                    n.done = 1'b0;
                end else if ((wbase == OFS_RDAT) || (wbase == OFS_WRAP)) begin
                    n.prdata = word_of(q.rblk, widx);
                end else begin
                    n.err = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule
`default_nettype wire

// [verif/bcas_assertions.sv]
// link checks between the host and dev ends of the auto sequencer
// assumes one clock domain with a synchronous active-low reset
`default_nettype none
module bcas_assertions (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic auto_en,
    input wire logic start,
    input wire logic decrypt,
    input wire logic hs_en,
    input wire logic [4:0] cmd,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic rd_valid,
    input wire logic rd_wrap,
    input wire logic rd_ready,
    input wire logic [bcas_pkg::BW-1:0] rd_data,
    input wire logic [bcas_pkg::BW-1:0] wrap_data,
    input wire logic busy,
    input wire logic req_in,
    input wire logic req_out,
    input wire logic unwrap_err
);
    import bcas_pkg::*;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_busy_on_start;
        start && auto_en && !busy |=> busy;
    endproperty
    a_busy_on_start: assert property (p_busy_on_start)
        else $error("no busy");
    property p_req_in_hold;
        req_in && auto_en && !(wr_valid && wr_ready) |=> req_in || !auto_en;
    endproperty
    a_req_in_hold: assert property (p_req_in_hold)
        else $error("req_in dropped");
    property p_req_out_hold;
        req_out && hs_en && !(rd_valid && rd_ready && !rd_wrap) |=> req_out || !hs_en;
    endproperty
    a_req_out_hold: assert property (p_req_out_hold)
        else $error("req_out dropped");
    property p_key_no_req;
        busy && cmd[CMD_KEY_BIT] |-> !req_in && !req_out;
    endproperty
    a_key_no_req: assert property (p_key_no_req)
        else $error("key req");
    property p_mac_read;
        $fell(busy) && cmd == CMD_MAC |->
            $past(rd_valid && rd_ready && !rd_wrap) || $past(rd_valid && rd_ready && !rd_wrap, 2);
    endproperty
    a_mac_read: assert property (p_mac_read)
        else $error("mac unread");
    property p_drain_busy;
        $fell(auto_en) && busy && !cmd[CMD_KEY_BIT] |=> busy;
    endproperty
    a_drain_busy: assert property (p_drain_busy)
        else $error("drain busy");
    property p_cmd_stable;
        busy |=> $stable(cmd);
    endproperty
    a_cmd_stable: assert property (p_cmd_stable)
        else $error("cmd changed");
    property p_wrap_read;
        rd_valid && rd_wrap |-> rd_ready;
    endproperty
    a_wrap_read: assert property (p_wrap_read)
        else $error("wrap stall");
    property p_wrap_result;
        $fell(busy) && cmd[CMD_KEY_BIT] && !decrypt |-> rd_data == wrap_data;
    endproperty
    a_wrap_result: assert property (p_wrap_result)
        else $error("wrap result");
    property p_unwrap_flush;
        $fell(busy) && cmd[CMD_KEY_BIT] && decrypt |-> rd_data == '0;
    endproperty
    a_unwrap_flush: assert property (p_unwrap_flush)
        else $error("no flush");
    property p_err_sticky;
        unwrap_err && !start |=> unwrap_err;
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("uerr lost");
endmodule
`default_nettype wire

// [verif/block_cipher_auto_sequencer_tb.sv]
// bench: apb-driven host and dev ends joined, stub cipher kernel
// assumes package, interface, ends and checker built first
`default_nettype none
module block_cipher_auto_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bcas_pkg::*;
    localparam logic [1:0] SLOT = 2'h2;
    localparam logic [127:0] KM = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
    localparam logic [127:0] IV = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    localparam logic [127:0] DA = 128'hDEAD_BEEF_0123_4567_89AB_CDEF_F00D_CAFE;
    localparam logic [127:0] DB = 128'h0BAD_F00D_7654_3210_FEDC_BA98_1357_9BDF;
    localparam logic [127:0] CT0 = 128'h0000_0001_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
    localparam logic [127:0] KEYV = 128'hC0DE_0001_C0DE_0002_C0DE_0003_C0DE_0004;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, dma_req_in_o, dma_req_out_o;
    logic k_start, k_skip, k_kop, k_dec, key_load;
    logic [127:0] k_din;
    logic [383:0] k_blk;
    logic [1:0] key_slot;
    logic kdone = 1'b0;
    logic kicv = 1'b0;
    logic [127:0] kres = '0;
    logic [2:0] kdly = 3'h0;
    logic [1:0] slot_seen = 2'h0;
    logic skip_log [0:63];
    int starts = 0;
    int loads = 0;
    int failures = 0;
    int comparisons = 0;
    bcas_if ifc();
    bcas_dev #(.KSW(2), .KEY_SLOT(SLOT)) i_bcas_dev (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .ifc(ifc.dev), .kern_start_o(k_start), .kern_skip_key_o(k_skip), .kern_key_op_o(k_kop),
        .kern_decrypt_o(k_dec), .kern_key256_o(), .kern_din_o(k_din), .kern_key_blk_o(k_blk),
        .kern_done_i(kdone), .kern_res_i(kres), .kern_icv_bad_i(kicv), .key_load_o(key_load),
        .key_slot_o(key_slot));
    bcas_host i_bcas_host (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ifc(ifc.host),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .dma_req_in_o(dma_req_in_o), .dma_req_out_o(dma_req_out_o));
    bcas_assertions i_bcas_assertions (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .auto_en(ifc.auto_en), .start(ifc.start), .decrypt(ifc.decrypt), .hs_en(ifc.hs_en),
        .cmd(ifc.cmd), .wr_valid(ifc.wr_valid), .wr_ready(ifc.wr_ready),
        .rd_valid(ifc.rd_valid), .rd_wrap(ifc.rd_wrap), .rd_ready(ifc.rd_ready),
        .rd_data(ifc.rd_data), .wrap_data(ifc.wrap_data), .busy(ifc.busy),
        .req_in(ifc.req_in), .req_out(ifc.req_out), .unwrap_err(ifc.unwrap_err));
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // stub kernel: xor mask for a cipher, done 3 cycles on
    always @(posedge ref_clk_i) begin
        kdone <= (kdly == 3'h1);
        if (k_start) begin
            kdly <= 3'h3;
            kres <= (k_kop ? k_blk[127:0] : k_din) ^ KM;
            kicv <= k_kop & k_dec;
            skip_log[starts] <= k_skip;
            starts <= starts + 1;
        end else if (kdly != 3'h0) begin
            kdly <= kdly - 3'h1;
        end
        if (key_load) begin
            loads <= loads + 1;
            slot_seen <= key_slot;
        end
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic timeout(input string what);
        failures++;
        $display("MISMATCH %s expected done seen timeout", what);
        wrap_up();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
            if (n > 2000) timeout("apb ready");
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic push(input logic [1:0] b, input logic [127:0] v);
        for (int i = 0; i < 4; i++) wr(OFS_WDAT + 8'(4 * i), v[32 * i +: 32]);
        wr(OFS_PUSH, {30'h0, b});
    endtask
    // word 0 pulls the block; words 1-3 read the copy taken then
    task automatic pull(input logic [7:0] base, output logic [127:0] v);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            rd(base + 8'(4 * i), r);
            v[32 * i +: 32] = r;
        end
    endtask
    task automatic go(input logic [31:0] ctrl, input logic [4:0] c, input logic [1:0] inc);
        wr(OFS_CTRL, ctrl);
        wr(OFS_CMD, {22'h0, inc, 3'h0, c});
        wr(OFS_CTRL, ctrl | 32'h4);
    endtask
    task automatic wait_idle;
        logic [31:0] s;
        int n = 0;
        do begin
            rd(OFS_STATUS, s);
            n++;
            if (n > 200) timeout("busy low");
        end while (s[SB_BUSY] !== 1'b0);
    endtask
    function automatic logic [127:0] inc(input logic [127:0] v, input logic [1:0] m);
        logic [127:0] k;
        k = (m == INCR_128) ? '1 : ((128'h1 << (32 * (m + 1))) - 128'h1);
        return (v & ~k) | ((v + 128'h1) & k);
    endfunction
    initial begin
        logic [31:0] s;
        logic [127:0] v, w;
        logic e, dec;
        logic [1:0] m;
        int s0, n, nb;
        repeat (3) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(posedge ref_clk_i);
        rd(OFS_STATUS, s);
        chk("reset status", 0, s);
        apb(1'b0, 8'hFC, 32'h0, s, e);
        chk("unmapped slverr", 1, e);
        go(32'h41, CMD_MAC, INCR_32);
        push(BANK_RES, IV);
        push(BANK_IN0, DA);
        push(BANK_IN0, DB);
        wr(OFS_CTRL, 32'h40);
        rd(OFS_STATUS, s);
        chk("drain busy", 1, s[SB_BUSY]);
        wr(OFS_CTRL, 32'h42);
        pull(OFS_RDAT, v);
        chk("mac", DB ^ DA ^ IV, v);
        rd(OFS_STATUS, s);
        chk("mac busy", 0, s[SB_BUSY]);
        $display("test mac done");
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            s0 = starts;
            go(32'h71, CMD_CTR, m);
            @(negedge ref_clk_i);
            chk("req in", 1, dma_req_in_o);
            @(posedge ref_clk_i);
            push(BANK_IN0, CT0);
            push(BANK_IN1, DA);
            push(BANK_IN1, DB);
            for (n = 0; dma_req_out_o !== 1'b1; n++) begin
                if (n > 100) timeout("req out");
                @(negedge ref_clk_i);
            end
            chk("req out", 1, dma_req_out_o);
            @(posedge ref_clk_i);
            pull(OFS_RDAT, v);
            pull(OFS_RDAT, w);
            wr(OFS_CTRL, 32'h70);
            wr(OFS_CTRL, 32'h72);
            wait_idle();
            chk("ctr 0", CT0, v ^ DA ^ KM);
            chk("ctr 1", inc(CT0, m), w ^ DB ^ KM);
            chk("launches", 2, starts - s0);
            chk("skip 0", 0, skip_log[s0]);
            chk("skip 1", 1, skip_log[s0 + 1]);
        end
        $display("test ctr done");
        for (int k = 0; k < 4; k++) begin
            dec = k[0];
            nb = 1 + k[0] + k[1];
            s0 = loads;
            go(dec ? 32'h59 : 32'h41, k[1] ? CMD_KW256 : CMD_KW128, INCR_32);
            @(negedge ref_clk_i);
            chk("key req", 0, dma_req_in_o);
            @(posedge ref_clk_i);
            for (int b = 0; b < nb; b++) push(2'(b), KEYV ^ 128'(b));
            wait_idle();
            rd(OFS_STATUS, s);
            chk("uerr", dec, s[SB_UERR]);
            if (dec) begin
                pull(OFS_RDAT, v);
                chk("flush", 0, v);
                chk("loads", 1, loads - s0);
                chk("key slot", SLOT, slot_seen);
            end else begin
                pull(OFS_WRAP, w);
                chk("wrap", KEYV ^ KM, w);
                pull(OFS_RDAT, v);
                chk("wrap res", KEYV ^ KM, v);
                chk("wrap loads", 0, loads - s0);
            end
            wr(OFS_CTRL, 32'h0);
        end
        $display("test keys done");
        wrap_up();
    end
endmodule
`default_nettype wire
